// ==== src/adcc_pkg.sv ====
package adcc_pkg;
   // apb byte addresses
   localparam logic [11:0] ADCC_OFF_CTRL0 = 12'h000;
   localparam logic [11:0] ADCC_OFF_CTRL1 = 12'h004;
   localparam logic [11:0] ADCC_OFF_RESULT = 12'h008;
   localparam logic [11:0] ADCC_OFF_STATUS = 12'h00C;
   localparam logic [11:0] ADCC_OFF_MASK = 12'h010;
   localparam logic [11:0] ADCC_OFF_TRIGCFG = 12'h014;
   // control register 0 fields
   localparam int ADCC_EN_BIT = 0;
   localparam int ADCC_GO_BIT = 1;
   localparam int ADCC_CHS_LSB = 2;
   // control register 1 fields
   localparam int ADCC_PCFG_LSB = 0;
   localparam int ADCC_POS_REF_BIT = 4;
   localparam int ADCC_NEG_REF_BIT = 5;
   // reset, strap and decode values
   localparam logic [5:0] ADCC_CTRL0_RST = 6'h00;
   localparam logic [1:0] ADCC_VREF_RST = 2'h0;
   localparam logic [3:0] ADCC_PCFG_ANALOG = 4'h0;
   localparam logic [3:0] ADCC_PCFG_MIXED = 4'h7;
   localparam logic [3:0] ADCC_TRIG_MODE = 4'hB;
   localparam logic [3:0] ADCC_CHAN_LAST = 4'hC;
   localparam logic [3:0] ADCC_PCFG_ALLA = 4'h2;
   // timing, status bit and states
   localparam int ADCC_CLK_MHZ = 100;
   localparam int ADCC_TAD_NS = 1600;
   localparam int ADCC_TAD_CYC = (ADCC_TAD_NS * ADCC_CLK_MHZ) / 1000;
   localparam int ADCC_CONV_TADS = 13;
   localparam int ADCC_STAT_DONE = 0;
   typedef enum logic [1:0] {
      ADCC_IDLE = 2'b00,
      ADCC_CONV = 2'b01,
      ADCC_STORE = 2'b10
   } adcc_state_t;
endpackage : adcc_pkg

// ==== src/adcc_top.sv ====
// Operation
// - channel codes 0 to 12 route inputs 0 to 12 to the converter
// - codes 13 to 15 select nothing; conversion still runs, result floats
// - go/status bit reads 1 during a conversion, 0 when idle
// - enable bit 0 of control 0 turns converter on, resets to 0
// - top two bits of both control registers ignore writes, read zero
// - negative reference from input 2 when set, ground when clear
// - positive reference from input 3 when set, supply when clear
// - power-on port config is 0000 if option is 1, else 0111
// - each conversion yields a 12-bit unsigned value
// - small variant has 10 inputs; inputs 5 to 7 only on large
// - sample capacitor disconnected from the pin during conversion
// - compare unit 2 trigger in mode 1011 starts conversion when enabled
// - conversion takes 13 to 14 conversion clock periods
// - result readable on the cycle after conversion ends
`timescale 1ns/1ps
module adcc_top
   import adcc_pkg::*;
#(
   parameter int NUM_INPUTS = 13
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // straps and triggers
   input wire logic portb_analog_default_option,
   input wire logic compare_unit2_trigger,
   input wire logic [3:0] compare_unit2_mode,
   // analog front end
   input wire logic [11:0] sar_sample,
   output logic [12:0] analog_input_route,
   output logic sample_hold_connect,
   output logic neg_reference_select,
   output logic pos_reference_select,
   // port pins
   input wire logic [12:0] pin_digital_in,
   output logic [12:0] pin_analog_mode,
   output logic [12:0] port_digital_in,
   // interrupt
   output logic irq
);
   import adcc_pkg::*;

   initial begin
      if (NUM_INPUTS != 10 && NUM_INPUTS != 13) begin
         $error("NUM_INPUTS must be 10 or 13");
      end
   end

   logic [5:0] ctrl0_r, ctrl0_nxt;
   logic [5:0] ctrl1_r, ctrl1_nxt;
   logic [11:0] result_r, result_nxt;
   logic stat_r, stat_nxt;
   logic mask_r, mask_nxt;
   logic trig_en_r, trig_en_nxt;
   logic strap_done_r, strap_done_nxt;
   adcc_state_t state_r, state_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic [31:0] prdata_nxt;
   logic pready_nxt, pslverr_nxt, irq_nxt;
   logic [12:0] route_nxt, amode_nxt, pdin_nxt;
   logic shc_nxt;
   logic [12:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_stable_r, pin_stable_nxt;
   logic trig_s1_r, trig_s2_r, trig_s3_r, trig_prev_r;
   logic wr_acc, wr_req, rd_acc, go_wr, trig_fire, done_evt;
   logic [12:0] impl_mask;
   logic [15:0] conv_len_r, conv_len_nxt;

   // a write commits only at the edge where the master sees pready high
   assign wr_acc = psel && penable && pwrite && pready;
   // access phase before the answer: decode for the error response
   assign wr_req = psel && penable && pwrite && !pready;
   assign rd_acc = psel && penable && !pwrite && !pready;
   assign go_wr = wr_acc && paddr == ADCC_OFF_CTRL0 && pwdata[ADCC_GO_BIT]
                  && pwdata[ADCC_EN_BIT];
   // trigger edge after stable agreement of second and third stages
   assign trig_fire = trig_s2_r && trig_s3_r && !trig_prev_r
                      && compare_unit2_mode == ADCC_TRIG_MODE;
   assign done_evt = state_r == ADCC_STORE;
   assign impl_mask = (NUM_INPUTS == 13) ? 13'h1FFF : 13'h1F1F;

   // pin and trigger synchronisers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_s1_r <= 13'h0000;
         pin_s2_r <= 13'h0000;
         pin_s3_r <= 13'h0000;
         trig_s1_r <= 1'b0;
         trig_s2_r <= 1'b0;
         trig_s3_r <= 1'b0;
         trig_prev_r <= 1'b0;
      end else begin
         pin_s1_r <= pin_digital_in;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         trig_s1_r <= compare_unit2_trigger;
         trig_s2_r <= trig_s1_r;
         trig_s3_r <= trig_s2_r;
         trig_prev_r <= trig_s2_r && trig_s3_r;
      end
   end

   always_comb begin
      ctrl0_nxt = ctrl0_r;
      ctrl1_nxt = ctrl1_r;
      result_nxt = result_r;
      stat_nxt = stat_r;
      mask_nxt = mask_r;
      trig_en_nxt = trig_en_r;
      strap_done_nxt = 1'b1;
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      prdata_nxt = 32'h00000000;
      pready_nxt = 1'b0;
      pslverr_nxt = 1'b0;
      // strap caught on the first clock after reset release
      if (!strap_done_r) begin
         ctrl1_nxt[3:0] = portb_analog_default_option ? ADCC_PCFG_ANALOG
                                                      : ADCC_PCFG_MIXED;
      end
      if (wr_req || rd_acc) begin
         pready_nxt = 1'b1;
      end
      if (wr_req) begin
         case (paddr)
            ADCC_OFF_CTRL0, ADCC_OFF_CTRL1, ADCC_OFF_RESULT: pslverr_nxt = 1'b0;
            ADCC_OFF_STATUS, ADCC_OFF_MASK, ADCC_OFF_TRIGCFG: pslverr_nxt = 1'b0;
            default: pslverr_nxt = 1'b1;
         endcase
      end
      if (wr_acc) begin
         case (paddr)
            ADCC_OFF_CTRL0: begin
               // bits 7:6 dropped, go set only by a start write or a compare unit 2 trigger
               ctrl0_nxt[5:2] = pwdata[5:2];
               ctrl0_nxt[ADCC_EN_BIT] = pwdata[ADCC_EN_BIT];
            end
            ADCC_OFF_CTRL1: ctrl1_nxt = pwdata[5:0];
            ADCC_OFF_STATUS: begin
               if (pwdata[ADCC_STAT_DONE]) begin
                  stat_nxt = 1'b0;
               end
            end
            ADCC_OFF_MASK: mask_nxt = pwdata[0];
            ADCC_OFF_TRIGCFG: trig_en_nxt = pwdata[0];
            default: ;
         endcase
      end
      if (rd_acc) begin
         case (paddr)
            ADCC_OFF_CTRL0: prdata_nxt = {26'h0, ctrl0_r};
            ADCC_OFF_CTRL1: prdata_nxt = {26'h0, ctrl1_r};
            ADCC_OFF_RESULT: prdata_nxt = {20'h0, result_r};
            ADCC_OFF_STATUS: prdata_nxt = {31'h0, stat_r};
            ADCC_OFF_MASK: prdata_nxt = {31'h0, mask_r};
            ADCC_OFF_TRIGCFG: prdata_nxt = {31'h0, trig_en_r};
            default: pslverr_nxt = 1'b1;
         endcase
      end
      case (state_r)
         ADCC_IDLE: begin
            // disabled converter ignores both start sources
            if (ctrl0_r[ADCC_EN_BIT] && (go_wr || (trig_fire && trig_en_r))) begin
               ctrl0_nxt[ADCC_GO_BIT] = 1'b1;
               cnt_nxt = 16'(ADCC_TAD_CYC * ADCC_CONV_TADS - 1);
               state_nxt = ADCC_CONV;
            end
         end
         ADCC_CONV: begin
            if (!ctrl0_nxt[ADCC_EN_BIT]) begin
               ctrl0_nxt[ADCC_GO_BIT] = 1'b0;
               state_nxt = ADCC_IDLE;
            end else if (cnt_r == 16'h0000) begin
               result_nxt = sar_sample;
               state_nxt = ADCC_STORE;
            end else begin
               cnt_nxt = cnt_r - 16'h0001;
            end
         end
         ADCC_STORE: begin
            ctrl0_nxt[ADCC_GO_BIT] = 1'b0;
            stat_nxt = 1'b1; // set wins over clear
            state_nxt = ADCC_IDLE;
         end
         default: state_nxt = ADCC_IDLE;
      endcase
   end

   always_comb begin
      route_nxt = 13'h0000;
      if (ctrl0_r[5:2] <= ADCC_CHAN_LAST) begin
         route_nxt[ctrl0_r[5:2]] = 1'b1;
      end
      route_nxt = route_nxt & impl_mask;
      for (int i = 0; i < 13; i++) begin
         // code 3 drops input 12, each code above drops one more
         amode_nxt[i] = impl_mask[i] && (ctrl1_r[3:0] <= ADCC_PCFG_ALLA
                        || 32'(ctrl1_r[3:0]) < 32'(15 - i));
      end
      // conversion started: capacitor off the pin
      shc_nxt = ctrl0_r[ADCC_EN_BIT] && state_nxt == ADCC_IDLE;
      pin_stable_nxt = pin_stable_r;
      for (int i = 0; i < 13; i++) begin
         if (pin_s2_r[i] == pin_s3_r[i]) begin
            pin_stable_nxt[i] = pin_s3_r[i];
         end
      end
      pdin_nxt = pin_stable_nxt & ~amode_nxt;
      irq_nxt = stat_nxt && mask_nxt;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl0_r <= ADCC_CTRL0_RST;
         ctrl1_r <= {ADCC_VREF_RST, ADCC_PCFG_ANALOG};
         result_r <= 12'h000;
         stat_r <= 1'b0;
         mask_r <= 1'b0;
         trig_en_r <= 1'b0;
         strap_done_r <= 1'b0;
         state_r <= ADCC_IDLE;
         cnt_r <= 16'h0000;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         analog_input_route <= 13'h0000;
         sample_hold_connect <= 1'b0;
         neg_reference_select <= 1'b0;
         pos_reference_select <= 1'b0;
         pin_analog_mode <= 13'h0000;
         port_digital_in <= 13'h0000;
         pin_stable_r <= 13'h0000;
         irq <= 1'b0;
      end else begin
         ctrl0_r <= ctrl0_nxt;
         ctrl1_r <= ctrl1_nxt;
         result_r <= result_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         trig_en_r <= trig_en_nxt;
         strap_done_r <= strap_done_nxt;
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         prdata <= prdata_nxt;
         pready <= pready_nxt;
         pslverr <= pslverr_nxt;
         analog_input_route <= route_nxt;
         sample_hold_connect <= shc_nxt;
         neg_reference_select <= ctrl1_nxt[ADCC_NEG_REF_BIT];
         pos_reference_select <= ctrl1_nxt[ADCC_POS_REF_BIT];
         pin_analog_mode <= amode_nxt;
         port_digital_in <= pdin_nxt;
         pin_stable_r <= pin_stable_nxt;
         irq <= irq_nxt;
      end
   end

   // length of the running conversion, for the timing check
   always_comb begin
      conv_len_nxt = 16'h0000;
      if (state_r == ADCC_CONV) begin
         conv_len_nxt = conv_len_r + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         conv_len_r <= 16'h0000;
      end else begin
         conv_len_r <= conv_len_nxt;
      end
   end

   // assertions
   conv_length_a: assert property (@(posedge clk) disable iff (!nrst)
      state_r == ADCC_STORE |-> conv_len_r >= 16'(ADCC_CONV_TADS * ADCC_TAD_CYC)
      && conv_len_r <= 16'((ADCC_CONV_TADS + 1) * ADCC_TAD_CYC))
      else $error("conversion length wrong");
   go_start_a: assert property (@(posedge clk) disable iff (!nrst)
      state_r == ADCC_IDLE && go_wr && ctrl0_r[ADCC_EN_BIT]
      |=> ctrl0_r[ADCC_GO_BIT] && state_r == ADCC_CONV)
      else $error("start write ignored");
   pready_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
      pready |=> !pready)
      else $error("pready longer than one cycle");
   bad_addr_a: assert property (@(posedge clk) disable iff (!nrst)
      pready && psel && paddr > ADCC_OFF_TRIGCFG |-> pslverr)
      else $error("unmapped address accepted");
   irq_level_a: assert property (@(posedge clk) disable iff (!nrst)
      irq == (stat_r && mask_r))
      else $error("interrupt level wrong");
   neg_ref_a: assert property (@(posedge clk) disable iff (!nrst)
      neg_reference_select == ctrl1_r[ADCC_NEG_REF_BIT])
      else $error("negative reference select wrong");
   pos_ref_a: assert property (@(posedge clk) disable iff (!nrst)
      pos_reference_select == ctrl1_r[ADCC_POS_REF_BIT])
      else $error("positive reference select wrong");
   go_busy_a: assert property (@(posedge clk) disable iff (!nrst)
      state_r == ADCC_CONV |-> ctrl0_r[ADCC_GO_BIT])
      else $error("go low while converting");
   go_clear_a: assert property (@(posedge clk) disable iff (!nrst)
      state_r == ADCC_STORE |=> !ctrl0_r[ADCC_GO_BIT] && stat_r)
      else $error("go not cleared at end");
   off_ignore_a: assert property (@(posedge clk) disable iff (!nrst)
      state_r == ADCC_IDLE && !ctrl0_r[ADCC_EN_BIT] |=> state_r == ADCC_IDLE)
      else $error("disabled converter started");
   hold_off_a: assert property (@(posedge clk) disable iff (!nrst)
      state_r == ADCC_CONV && $past(state_r) == ADCC_CONV |-> !sample_hold_connect)
      else $error("capacitor connected during conversion");
   top_bits_a: assert property (@(posedge clk) disable iff (!nrst)
      pready && !pwrite && paddr == ADCC_OFF_CTRL0 |-> prdata[31:6] == 26'h0)
      else $error("upper bits not zero");
   analog_zero_a: assert property (@(posedge clk) disable iff (!nrst)
      (port_digital_in & pin_analog_mode) == 13'h0000)
      else $error("analog pin reads one");
   route_bad_a: assert property (@(posedge clk) disable iff (!nrst)
      ctrl0_r[5:2] > ADCC_CHAN_LAST |=> analog_input_route == 13'h0000)
      else $error("unimplemented code routed");
   all_digital_a: assert property (@(posedge clk) disable iff (!nrst)
      ctrl1_r[3:0] == 4'hF |=> pin_analog_mode == 13'h0000)
      else $error("pin analog at code 1111");
   strap_a: assert property (@(posedge clk) disable iff (!nrst)
      !strap_done_r && !portb_analog_default_option |=> ctrl1_r[3:0] == ADCC_PCFG_MIXED)
      else $error("strap default wrong");
endmodule : adcc_top

// ==== testbench/adcc_far_model.sv ====
`timescale 1ns/1ps
module adcc_far_model (
   // clock
   input wire logic clk,
   // converter side
   input wire logic [12:0] analog_input_route,
   output logic [11:0] sar_sample,
   // pins
   output logic [12:0] pin_digital_in
);
   logic [11:0] noise_r = 12'h000;
   // an unrouted input floats: the value wanders every cycle
   always_ff @(posedge clk) begin
      noise_r <= noise_r + 12'h3B1;
   end
   always_comb begin
      sar_sample = noise_r;
      for (int i = 0; i < 13; i++) begin
         if (analog_input_route[i]) begin
            sar_sample = {8'hA5, 4'(i)};
         end
      end
   end
   assign pin_digital_in = 13'h1FFF;
endmodule : adcc_far_model

// ==== testbench/adcc_top_bench.sv ====
`timescale 1ns/1ps
module adcc_top_bench;
   import adcc_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic strap = 1'b0, trig = 1'b0, er, pready, pslverr, s_conn, nref, pref, irq;
   logic [3:0] mode = 4'h0;
   logic [11:0] paddr = 12'h000, sample;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic [12:0] route, pins, amode, pdin, m;
   int fail_count = 0, n_tests = 0, k, n;

   always #5 clk = ~clk;

   adcc_top i_adcc_top (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .portb_analog_default_option(strap), .compare_unit2_trigger(trig),
      .compare_unit2_mode(mode), .sar_sample(sample), .analog_input_route(route),
      .sample_hold_connect(s_conn), .neg_reference_select(nref),
      .pos_reference_select(pref), .pin_digital_in(pins), .pin_analog_mode(amode),
      .port_digital_in(pdin), .irq(irq));
   adcc_far_model i_adcc_far_model (.clk(clk), .analog_input_route(route),
      .sar_sample(sample), .pin_digital_in(pins));

   task final_report;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : final_report

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) chk("pready", 32'h0, 32'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task rst(input logic s);
      nrst <= 1'b0; strap <= s;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : rst

   task pulse(input logic [3:0] md);
      mode <= md; trig <= 1'b1;
      repeat (6) @(posedge clk);
      trig <= 1'b0;
      repeat (6) @(posedge clk);
      apb(1'b0, ADCC_OFF_CTRL0, 32'h0);
   endtask : pulse

   task wait_irq;
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_irq

   initial begin
      rst(1'b1);
      apb(1'b0, ADCC_OFF_CTRL1, 32'h0); chk("pcfg strap1", rd, 32'h0);
      rst(1'b0);
      apb(1'b0, ADCC_OFF_CTRL1, 32'h0); chk("pcfg strap0", rd, 32'h7);
      apb(1'b0, ADCC_OFF_CTRL0, 32'h0); chk("ctrl0 reset", rd, 32'h0);
      apb(1'b1, ADCC_OFF_CTRL1, 32'hFF); apb(1'b0, ADCC_OFF_CTRL1, 32'h0);
      chk("ctrl1 top bits", rd, 32'h3F);
      chk("refs set", {30'h0, nref, pref}, 32'h3);
      for (int p = 0; p < 16; p++) begin
         m = (p <= 2) ? 13'h1FFF : 13'h1FFF >> (p - 2);
         apb(1'b1, ADCC_OFF_CTRL1, 32'(p));
         repeat (4) @(posedge clk);
         chk("analog mode", {19'h0, amode}, {19'h0, m});
         chk("port in", {19'h0, pdin}, {19'h0, ~m});
      end
      chk("refs clear", {30'h0, nref, pref}, 32'h0);
      for (int c = 0; c < 16; c++) begin
         apb(1'b1, ADCC_OFF_CTRL0, {24'h0, 2'b11, 4'(c), 2'b01});
         apb(1'b0, ADCC_OFF_CTRL0, 32'h0);
         chk("ctrl0 top bits", rd, {26'h0, 4'(c), 2'b01});
         repeat (2) @(posedge clk);
         chk("route", {19'h0, route}, (c < 13) ? 32'h1 << c : 32'h0);
      end
      chk("hold connect idle", {31'h0, s_conn}, 32'h1);
      apb(1'b1, ADCC_OFF_CTRL0, 32'h0E); apb(1'b0, ADCC_OFF_CTRL0, 32'h0);
      chk("go while off", rd, 32'h0C);
      apb(1'b0, 12'h020, 32'h0); chk("unmapped", {31'h0, er}, 32'h1);
      apb(1'b1, ADCC_OFF_MASK, 32'h1);
      apb(1'b1, ADCC_OFF_CTRL0, 32'h0D);
      repeat (300) @(posedge clk);
      apb(1'b1, ADCC_OFF_CTRL0, 32'h0F); apb(1'b0, ADCC_OFF_CTRL0, 32'h0);
      chk("busy", rd, 32'h0F);
      chk("hold connect busy", {31'h0, s_conn}, 32'h0);
      wait_irq;
      chk("conv time", {31'h0, n >= 2000 && n <= 2250}, 32'h1);
      apb(1'b0, ADCC_OFF_RESULT, 32'h0); chk("result", rd, 32'h00000A53);
      apb(1'b0, ADCC_OFF_CTRL0, 32'h0); chk("done", rd, 32'h0D);
      apb(1'b0, ADCC_OFF_STATUS, 32'h0); chk("status", rd, 32'h1);
      apb(1'b1, ADCC_OFF_STATUS, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      apb(1'b1, ADCC_OFF_TRIGCFG, 32'h1);
      apb(1'b1, ADCC_OFF_CTRL0, 32'h0C);
      pulse(ADCC_TRIG_MODE); chk("trig off", rd, 32'h0C);
      apb(1'b1, ADCC_OFF_CTRL0, 32'h0D);
      pulse(4'hA); chk("trig mode", rd, 32'h0D);
      pulse(ADCC_TRIG_MODE); chk("trig go", rd, 32'h0F);
      wait_irq;
      chk("trig irq", {31'h0, irq}, 32'h1);
      apb(1'b1, ADCC_OFF_MASK, 32'h0);
      repeat (2) @(posedge clk);
      chk("irq masked", {31'h0, irq}, 32'h0);
      apb(1'b0, ADCC_OFF_STATUS, 32'h0); chk("status kept", rd, 32'h1);
      final_report;
   end

   initial begin
      #300000;
      fail_count++;
      final_report;
   end
endmodule : adcc_top_bench
